// *** logic/dma_engine.sv ***
// three-channel dma engine with two-entry command buffer
//
// How it works
// - each channel holds 16-bit source and destination bases as byte halves.
// - four-bit step field picks inc, dec or static for source and destination.
// - per-channel size bit selects byte or word moves.
// - loop enable chooses whether the channel keeps running from base after a block.
// - priority bit chooses dma requests over cpu interrupts.
// - wait-enable bit allows transfers while the cpu waits.
// - per-channel interrupt enable permits an interrupt on completion.
// - two-bit bandwidth field limits how much bus time dma uses.
// - software request bits raise requests on their source inputs.
// - eight service request inputs from timer and serial units.
// - three-bit source select ties each channel to one request input.
// - software start needs enable, assignment and the matching request bit.
// - byte counter counts each byte; reaching block length sets done flag.
// - done flag with interrupt enable raises the cpu interrupt request.
// - single channel latency from request to transfer is two cycles.
// - writing another channel's setup mid-transfer adds three cycles.
// - at least one idle cycle separates transfers while several channels wait.
// - address is base plus, minus, or ignoring the byte count.
// - after the block the channel stops, or loops to base and continues.
// - reaching block length clears the transfer enable of a channel without loop enable.
// - without wait-enable, wait mode suspends the current transfer.
`timescale 1ns/1ps

module dma_cmd_buf #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic             wr_q;
  logic             rd_q;
  logic [1:0]       cnt_q;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = cnt_q != 2'h2;
  assign out_valid = cnt_q != 2'h0;
  assign out_data  = mem_q[rd_q];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (do_wr) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (do_wr) begin
        wr_q <= ~wr_q;
      end
      if (do_rd) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule

module dma_engine (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire dma_pkg::chan_cfg_t        chan_cfg [dma_pkg::NCH],
  input  wire logic                      xfer_en_wr,
  input  wire logic [dma_pkg::NCH-1:0]   xfer_en_wdata,
  output logic [dma_pkg::NCH-1:0]        chan_xfer_enable,
  input  wire logic [dma_pkg::NCH-1:0]   chan_irq_enable,
  output logic [dma_pkg::NCH-1:0]        chan_done_flag,
  input  wire logic [dma_pkg::NCH-1:0]   done_clr,
  output logic                           irq_req,
  input  wire logic                      bandwidth_sel_lo,
  input  wire logic                      bandwidth_sel_hi,
  input  wire logic                      dma_over_irq_priority,
  input  wire logic                      wait_mode_allow,
  input  wire logic                      cpu_in_wait,
  input  wire logic                      cpu_irq_pending,
  input  wire logic                      cfg_wr_valid,
  input  wire logic [dma_pkg::CH_W-1:0]  cfg_wr_chan,
  input  wire logic [dma_pkg::NSRC-1:0]  periph_req,
  input  wire logic [dma_pkg::NSRC-1:0]  soft_request_bit,
  output logic                           cmd_valid,
  input  wire logic                      cmd_ready,
  output dma_pkg::xfer_cmd_t             cmd,
  output logic                           dma_busy
);
  import dma_pkg::*;

  logic [NCH-1:0]   en_q;
  logic [NCH-1:0]   flag_q;
  logic [NCH-1:0]   pend;
  logic [NCH-1:0]   done_now;
  logic [NCH-1:0]   cur_hot;
  logic [LEN_W-1:0] cnt_q [NCH];
  eng_state_t       st_q;
  logic [CH_W-1:0]  cur_q;
  logic [CH_W-1:0]  pick;
  logic             hi_q;
  logic [1:0]       pen_q;
  logic [1:0]       gap_q;
  logic [1:0]       gap_need;
  logic             stall;
  logic             push;
  logic             push_rdy;
  logic             other_pend;
  logic             pen_hit;
  logic             arb_hold;
  xfer_cmd_t        cmd_d;
  chan_cfg_t        cur_cfg;

  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] base,
                                                  input logic [1:0]        step,
                                                  input logic [LEN_W-1:0]  cnt,
                                                  input logic              hi);
    logic [ADDR_W-1:0] off;
    off = ADDR_W'(cnt);
    case (step)
      STEP_INC: step_addr = base + off;
      STEP_DEC: step_addr = base - off;
      default:  step_addr = base + ADDR_W'(hi);
    endcase
  endfunction

  // wait mode without permission and cpu interrupts ahead of dma both hold the engine
  assign stall = (cpu_in_wait & ~wait_mode_allow)
               | (cpu_irq_pending & ~dma_over_irq_priority);

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [LEN_W-1:0] nxt;
      logic             fire;
      logic             arm;
      assign cur_hot[i] = cur_q == CH_W'(i);
      assign pend[i] = en_q[i] & (periph_req[chan_cfg[i].request_source_sel]
                     | soft_request_bit[chan_cfg[i].request_source_sel]);
      assign fire        = push & cur_hot[i];
      assign nxt         = cnt_q[i] + LEN_W'(1);
      assign done_now[i] = fire & (nxt == chan_cfg[i].chan_block_len);
      assign arm         = xfer_en_wr & xfer_en_wdata[i] & ~en_q[i];

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          cnt_q[i] <= '0;
        end else if (arm) begin
          cnt_q[i] <= '0;
        end else if (done_now[i]) begin
          cnt_q[i] <= '0;
        end else if (fire) begin
          cnt_q[i] <= nxt;
        end
      end

      // a software write in the same cycle wins over the hardware clear
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          en_q[i] <= 1'b0;
        end else if (xfer_en_wr) begin
          en_q[i] <= xfer_en_wdata[i];
        end else if (done_now[i] & ~chan_cfg[i].chan_loop_enable) begin
          en_q[i] <= 1'b0;
        end
      end

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          flag_q[i] <= 1'b0;
        end else if (done_now[i]) begin
          flag_q[i] <= 1'b1;
        end else if (done_clr[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign chan_xfer_enable = en_q;
  assign chan_done_flag   = flag_q;
  assign irq_req          = |(flag_q & chan_irq_enable);
  assign dma_busy         = st_q != ST_IDLE;

  // lowest channel number wins arbitration
  always_comb begin
    pick = '0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (pend[k]) begin
        pick = CH_W'(k);
      end
    end
  end

  assign other_pend = |(pend & ~cur_hot);
  assign gap_need   = other_pend && ({bandwidth_sel_hi, bandwidth_sel_lo} < MULTI_GAP)
                    ? MULTI_GAP : {bandwidth_sel_hi, bandwidth_sel_lo};
  assign cur_cfg    = chan_cfg[cur_q];
  assign push       = (st_q == ST_MOVE) & ~stall & push_rdy & en_q[cur_q];
  assign pen_hit    = cfg_wr_valid && st_q != ST_IDLE && cfg_wr_chan != cur_q;
  assign arb_hold   = stall | pen_hit | ~en_q[cur_q];

  always_comb begin
    cmd_d           = '0;
    cmd_d.chan      = cur_q;
    cmd_d.word      = cur_cfg.byte_word_sel;
    cmd_d.high_byte = hi_q;
    cmd_d.src_addr  = step_addr({cur_cfg.src_base_hi, cur_cfg.src_base_lo},
                                cur_cfg.addr_step_ctrl[SRC_STEP_LSB +: 2],
                                cnt_q[cur_q], hi_q);
    cmd_d.dst_addr  = step_addr({cur_cfg.dst_base_hi, cur_cfg.dst_base_lo},
                                cur_cfg.addr_step_ctrl[DST_STEP_LSB +: 2],
                                cnt_q[cur_q], hi_q);
  end

  // a word is moved as two back-to-back bytes, low byte first
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q  <= ST_IDLE;
      cur_q <= '0;
      hi_q  <= 1'b0;
      gap_q <= GAP_NONE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (|pend && !stall) begin
            cur_q <= pick;
            st_q  <= ST_ARB;
          end
        end
        ST_ARB: begin
          if (!en_q[cur_q]) begin
            st_q <= ST_IDLE;
          end else if (pen_q == PEN_NONE && !pen_hit && !stall) begin
            st_q <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (!en_q[cur_q]) begin
            hi_q <= 1'b0;
            st_q <= ST_IDLE;
          end else if (push) begin
            if (cur_cfg.byte_word_sel && !hi_q && !done_now[cur_q]) begin
              hi_q <= 1'b1;
            end else begin
              hi_q  <= 1'b0;
              gap_q <= gap_need;
              st_q  <= (gap_need == GAP_NONE) ? ST_IDLE : ST_GAP;
            end
          end
        end
        ST_GAP: begin
          gap_q <= gap_q - GAP_LAST;
          if (gap_q <= GAP_LAST) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pen_q <= PEN_NONE;
    end else if (pen_hit) begin
      // the write cycle itself already holds arbitration once
      pen_q <= (st_q == ST_ARB) ? CFG_PENALTY - GAP_LAST : CFG_PENALTY;
    end else if (st_q == ST_ARB && pen_q != PEN_NONE) begin
      pen_q <= pen_q - GAP_LAST;
    end
  end

  dma_cmd_buf #(
    .WIDTH ($bits(xfer_cmd_t))
  ) u_buf (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (push_rdy),
    .in_data   (cmd_d),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (cmd)
  );

  // the penalty only stretches the arbitration phase, never an issued byte
  lat_two_a: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q == ST_IDLE && |pend && !stall && pen_q == PEN_NONE && !cfg_wr_valid
    |=> st_q == ST_ARB ##1 (st_q == ST_MOVE || $past(arb_hold)))
    else $error("request did not reach transfer in two cycles");

  cfg_penalty_a: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q == ST_ARB && cfg_wr_valid && cfg_wr_chan != cur_q
    |=> st_q != ST_MOVE [*3])
    else $error("setup write did not add three cycles");

  multi_gap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    push && !(cur_cfg.byte_word_sel && !hi_q && !done_now[cur_q]) && other_pend
    |=> st_q == ST_GAP)
    else $error("no idle cycle between channel transfers");

  done_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
    push && cnt_q[cur_q] + LEN_W'(1) == cur_cfg.chan_block_len
    |=> flag_q[$past(cur_q)])
    else $error("done flag not set at block length");

  stop_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
    |done_now && !cur_cfg.chan_loop_enable && !xfer_en_wr
    |=> !en_q[$past(cur_q)])
    else $error("channel still enabled after block");

  loop_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
    |done_now && cur_cfg.chan_loop_enable && !xfer_en_wr
    |=> en_q[$past(cur_q)] && cnt_q[$past(cur_q)] == '0)
    else $error("looping channel did not wrap");

  irq_out_a: assert property (@(posedge core_clk) disable iff (!nrst)
    irq_req == |(chan_done_flag & chan_irq_enable))
    else $error("interrupt request disagrees with flags");

  wait_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cpu_in_wait && !wait_mode_allow |-> !push)
    else $error("transfer moved during forbidden wait");

  prio_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cpu_irq_pending && !dma_over_irq_priority && st_q == ST_IDLE |=> st_q == ST_IDLE)
    else $error("dma started ahead of cpu interrupt");

  addr_inc_a: assert property (@(posedge core_clk) disable iff (!nrst)
    push && cur_cfg.addr_step_ctrl[SRC_STEP_LSB +: 2] == STEP_INC
    |-> cmd_d.src_addr == {cur_cfg.src_base_hi, cur_cfg.src_base_lo}
        + ADDR_W'(cnt_q[cur_q]))
    else $error("incremented source address wrong");
endmodule

// *** logic/dma_pkg.sv ***
// shared constants and types of the three-channel dma engine
package dma_pkg;
  localparam int NCH    = 3;
  localparam int CH_W   = 2;
  localparam int NSRC   = 8;
  localparam int SEL_W  = 3;
  localparam int ADDR_W = 16;
  localparam int LEN_W  = 8;

  // addr_step_ctrl: source step in bits 1:0, destination step in bits 3:2
  localparam int          SRC_STEP_LSB = 0;
  localparam int          DST_STEP_LSB = 2;
  localparam logic [1:0]  STEP_INC     = 2'h1;
  localparam logic [1:0]  STEP_DEC     = 2'h2;

  // extra cycles when another channel's setup is written mid-transfer
  localparam logic [1:0]  CFG_PENALTY  = 2'h3;
  // least idle cycles between transfers while other channels wait
  localparam logic [1:0]  MULTI_GAP    = 2'h1;
  localparam logic [1:0]  GAP_NONE     = 2'h0;
  localparam logic [1:0]  PEN_NONE     = 2'h0;
  localparam logic [1:0]  GAP_LAST     = 2'h1;

  typedef struct packed {
    logic [7:0]       src_base_hi;
    logic [7:0]       src_base_lo;
    logic [7:0]       dst_base_hi;
    logic [7:0]       dst_base_lo;
    logic [3:0]       addr_step_ctrl;
    logic             byte_word_sel;
    logic [SEL_W-1:0] request_source_sel;
    logic [LEN_W-1:0] chan_block_len;
    logic             chan_loop_enable;
  } chan_cfg_t;

  typedef struct packed {
    logic [CH_W-1:0]   chan;
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic              word;
    logic              high_byte;
  } xfer_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARB  = 2'b01,
    ST_MOVE = 2'b10,
    ST_GAP  = 2'b11
  } eng_state_t;
endpackage

// *** bench/cmd_sink.sv ***
// bus-side model that executes transfer commands and can stall them
`timescale 1ns/1ps
module cmd_sink (
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic               hold,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire dma_pkg::xfer_cmd_t cmd,
  output logic                    got,
  output dma_pkg::xfer_cmd_t      seen,
  output int                      n_got
);
  import dma_pkg::*;
  // a held sink refuses like a busy bus; the engine must keep every word
  assign cmd_ready = !hold;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      got   <= 1'b0;
      seen  <= '0;
      n_got <= 0;
    end else begin
      got <= cmd_valid && cmd_ready;
      if (cmd_valid && cmd_ready) begin
        seen  <= cmd;
        n_got <= n_got + 1;
      end
    end
  end
endmodule

// *** bench/dma_engine_tb_top.sv ***
// self-checking bench of the dma engine against a stalling command sink
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module dma_engine_tb_top;
  import dma_pkg::*;
  logic            core_clk = 1'b0;
  logic            nrst = 1'b0;
  chan_cfg_t       chan_cfg [NCH];
  logic            xfer_en_wr = 1'b0;
  logic [NCH-1:0]  xfer_en_wdata = '0;
  logic [NCH-1:0]  chan_xfer_enable;
  logic [NCH-1:0]  chan_irq_enable = '0;
  logic [NCH-1:0]  chan_done_flag;
  logic [NCH-1:0]  done_clr = '0;
  logic            irq_req;
  logic            dma_over_irq_priority = 1'b1;
  logic            wait_mode_allow = 1'b1;
  logic            cpu_in_wait = 1'b0;
  logic            cpu_irq_pending = 1'b0;
  logic [NSRC-1:0] periph_req = '0;
  logic [NSRC-1:0] soft_request_bit = '0;
  logic            cmd_valid;
  logic            cmd_ready;
  xfer_cmd_t       cmd;
  logic            dma_busy;
  logic            hold = 1'b0;
  logic            cfg_wr_valid = 1'b0;
  logic [CH_W-1:0] cfg_wr_chan = '0;
  logic [1:0]      bw_sel = '0;
  logic            got;
  xfer_cmd_t       seen;
  int              n_got;
  int              fail_count = 0;
  int              n_compared = 0;
  int              lat;
  int              base;
  initial for (int c = 0; c < NCH; c++) chan_cfg[c] = '0;
  always #2 core_clk = ~core_clk;
  dma_engine u_dma_engine (
    .core_clk(core_clk), .nrst(nrst), .chan_cfg(chan_cfg), .xfer_en_wr(xfer_en_wr),
    .xfer_en_wdata(xfer_en_wdata), .chan_xfer_enable(chan_xfer_enable),
    .chan_irq_enable(chan_irq_enable), .chan_done_flag(chan_done_flag),
    .done_clr(done_clr), .irq_req(irq_req), .bandwidth_sel_lo(bw_sel[0]),
    .bandwidth_sel_hi(bw_sel[1]), .dma_over_irq_priority(dma_over_irq_priority),
    .wait_mode_allow(wait_mode_allow), .cpu_in_wait(cpu_in_wait),
    .cpu_irq_pending(cpu_irq_pending), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_chan(cfg_wr_chan),
    .periph_req(periph_req), .soft_request_bit(soft_request_bit), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .dma_busy(dma_busy));
  cmd_sink u_cmd_sink (
    .core_clk(core_clk), .nrst(nrst), .hold(hold), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .got(got), .seen(seen), .n_got(n_got));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic set_en(input logic [NCH-1:0] v);
    @(posedge core_clk);
    xfer_en_wr    <= 1'b1;
    xfer_en_wdata <= v;
    @(posedge core_clk);
    xfer_en_wr    <= 1'b0;
  endtask
  task automatic clr(input logic [NCH-1:0] v);
    @(posedge core_clk);
    done_clr <= v;
    @(posedge core_clk);
    done_clr <= '0;
  endtask
  // setup is only touched while the channel is off
  task automatic setup(input int ch, input logic [15:0] s, input logic [15:0] d,
                       input logic [3:0] st, input logic w, input logic [2:0] sel,
                       input logic [7:0] len, input logic lp);
    @(posedge core_clk);
    chan_cfg[ch] <= '{src_base_hi: s[15:8], src_base_lo: s[7:0], dst_base_hi: d[15:8],
                      dst_base_lo: d[7:0], addr_step_ctrl: st, byte_word_sel: w,
                      request_source_sel: sel, chan_block_len: len, chan_loop_enable: lp};
  endtask
  task automatic expect_cmd(input logic [1:0] ch, input logic [15:0] s,
                            input logic [15:0] d, input logic w, input logic h);
    int n;
    n = 0;
    do begin
      // flops are read at the edge before it updates them
      @(posedge core_clk);
      n++;
    end while (got !== 1'b1 && n < 200);
    `CHK(got, 1'b1)
    `CHK(seen, xfer_cmd_t'{ch, s, d, w, h})
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    tick(20000);
    fail_count++;
    end_sim();
  end
  initial begin
    tick(20);
    nrst <= 1'b1;
    // byte block, source up and destination down, sink stalled at first
    hold <= 1'b1;
    setup(0, 16'h1200, 16'h3400, 4'h9, 1'b0, 3'h2, 8'h03, 1'b0);
    chan_irq_enable <= 3'h1;
    set_en(3'h1);
    periph_req <= 8'h04;
    tick(20);
    `CHK(n_got, 0)
    `CHK(cmd_valid, 1'b1)
    hold <= 1'b0;
    expect_cmd(2'h0, 16'h1200, 16'h3400, 1'b0, 1'b0);
    expect_cmd(2'h0, 16'h1201, 16'h33FF, 1'b0, 1'b0);
    expect_cmd(2'h0, 16'h1202, 16'h33FE, 1'b0, 1'b0);
    tick(3);
    `CHK(chan_done_flag[0], 1'b1)
    `CHK(chan_xfer_enable[0], 1'b0)
    `CHK(irq_req, 1'b1)
    tick(10);
    `CHK(n_got, 3)
    clr(3'h1);
    tick(1);
    `CHK(irq_req, 1'b0)
    periph_req <= '0;
    // word block, static addresses, looping, started by software
    setup(1, 16'h5000, 16'h6000, 4'h0, 1'b1, 3'h7, 8'h04, 1'b1);
    set_en(3'h2);
    @(posedge core_clk);
    soft_request_bit <= 8'h80;
    lat = 0;
    do begin
      @(posedge core_clk);
      lat++;
    end while (cmd_valid !== 1'b1 && lat < 50);
    `CHK(lat, 4)
    for (int k = 0; k < 6; k++)
      expect_cmd(2'h1, 16'h5000 + 16'(k % 2), 16'h6000 + 16'(k % 2), 1'b1, k[0]);
    `CHK(chan_xfer_enable[1], 1'b1)
    `CHK(chan_done_flag[1], 1'b1)
    `CHK(irq_req, 1'b0)
    set_en(3'h0);
    soft_request_bit <= '0;
    tick(10);
    clr(3'h7);
    // wait mode and pending interrupt both hold the engine
    setup(2, 16'h00A0, 16'h00B0, 4'h0, 1'b0, 3'h5, 8'h02, 1'b0);
    cpu_in_wait     <= 1'b1;
    wait_mode_allow <= 1'b0;
    set_en(3'h4);
    periph_req <= 8'h20;
    tick(15);
    base = n_got;
    tick(10);
    `CHK(n_got, base)
    wait_mode_allow       <= 1'b1;
    cpu_irq_pending       <= 1'b1;
    dma_over_irq_priority <= 1'b0;
    tick(10);
    `CHK(n_got, base)
    cpu_irq_pending       <= 1'b0;
    dma_over_irq_priority <= 1'b1;
    expect_cmd(2'h2, 16'h00A0, 16'h00B0, 1'b0, 1'b0);
    cpu_irq_pending       <= 1'b1;
    dma_over_irq_priority <= 1'b0;
    tick(20);
    `CHK(n_got, base + 1)
    dma_over_irq_priority <= 1'b1;
    expect_cmd(2'h2, 16'h00A0, 16'h00B0, 1'b0, 1'b0);
    cpu_irq_pending <= 1'b0;
    periph_req <= '0;
    clr(3'h4);
    // every source input, with all other sources tried first
    for (int i = 0; i < NSRC; i++) begin
      setup(2, 16'h0100 + 16'(i), 16'h0200, 4'h0, 1'b0, 3'(i), 8'h01, 1'b0);
      set_en(3'h4);
      periph_req <= ~(8'h01 << i);
      tick(10);
      `CHK(n_got, base + 2 + i)
      periph_req <= 8'h01 << i;
      expect_cmd(2'h2, 16'h0100 + 16'(i), 16'h0200, 1'b0, 1'b0);
      periph_req <= '0;
      clr(3'h4);
    end
    // setup write to another channel stretches arbitration
    setup(0, 16'h0700, 16'h0800, 4'h0, 1'b0, 3'h1, 8'h01, 1'b0);
    set_en(3'h1);
    periph_req <= 8'h02;
    @(posedge core_clk);
    cfg_wr_valid <= 1'b1;
    cfg_wr_chan  <= 2'h2;
    @(posedge core_clk);
    cfg_wr_valid <= 1'b0;
    lat = 2;
    do begin
      @(posedge core_clk);
      lat++;
    end while (cmd_valid !== 1'b1 && lat < 50);
    `CHK(lat, 7)
    expect_cmd(2'h0, 16'h0700, 16'h0800, 1'b0, 1'b0);
    periph_req <= '0;
    // bandwidth code forces idle cycles between bytes
    bw_sel <= 2'h2;
    setup(0, 16'h0900, 16'h0A00, 4'h0, 1'b0, 3'h3, 8'h02, 1'b0);
    set_en(3'h1);
    periph_req <= 8'h08;
    expect_cmd(2'h0, 16'h0900, 16'h0A00, 1'b0, 1'b0);
    lat = 0;
    do begin
      @(posedge core_clk);
      lat++;
    end while (got !== 1'b1 && lat < 50);
    `CHK(lat, 5)
    `CHK(seen, xfer_cmd_t'{2'h0, 16'h0900, 16'h0A00, 1'b0, 1'b0})
    periph_req <= '0;
    bw_sel     <= 2'h0;
    // two channels pending: lower number goes first
    setup(0, 16'h0300, 16'h0400, 4'h0, 1'b0, 3'h0, 8'h01, 1'b0);
    setup(2, 16'h0500, 16'h0600, 4'h0, 1'b0, 3'h0, 8'h01, 1'b0);
    set_en(3'h5);
    periph_req <= 8'h01;
    expect_cmd(2'h0, 16'h0300, 16'h0400, 1'b0, 1'b0);
    expect_cmd(2'h2, 16'h0500, 16'h0600, 1'b0, 1'b0);
    periph_req <= '0;
    tick(5);
    end_sim();
  end
endmodule
